/* File: pscb_status_command.sv */
// module: upper status half and parity-response command bit of the interface status/command register
`timescale 1ns/1ps
`default_nettype none

// Operation
// - initiator got target abort sets bit 28
// - target signalled target abort sets bit 27
// - abort/parity bits clear on written one only
// - devsel timing field reads 01 medium
// - initiator parity error sets bit 24 when enabled
// - bit 24 stays clear otherwise
// - bit 23 reads one, fast back-to-back
// - bit 22 reserved, no function
// - capability list bit 20 reads zero
// - interrupt status bit 19 reserved
// - interrupt disable bit 10 reserved
// - parity response off: record only, no PERR#
// - satellite mode: local writes ignored
module pscb_status_command import pscb_pkg::*; (
    // clock, enable and reset
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic reset_n_i,
    // link side; abort and parity events sampled on the link clock's rising edge
    input wire logic pci_clk_i,
    input wire logic satellite_mode_i,
    input wire logic init_target_abort_i,
    input wire logic tgt_target_abort_i,
    input wire logic init_rd_parity_err_i,
    input wire logic init_wr_perr_seen_i,
    input wire logic tgt_parity_err_i,
    // processor-side register write
    input wire logic cpu_we_i,
    input wire logic [REG_W-1:0] cpu_wdata_i,
    // remote host configuration write
    input wire logic cfg_we_i,
    input wire logic [REG_W-1:0] cfg_wdata_i,
    // register contents and parity error pin
    output logic [REG_W-1:0] rdata_o,
    output logic perr_n_o,
    output logic perr_oe_o
);
    logic [SYNC_W-1:0] sy;
    logic pclk_prev_q;
    logic pedge;
    logic parity_error_response_enable;
    logic wr_en;
    logic [REG_W-1:0] wr_data;
    logic init_perr_event;
    logic bus_perr_event;
    logic perr_drive;
    logic [REG_W-1:0] rd_value;

    pscb_stat_if st ();

    // ========================================================================
    // link input synchronisers
    pscb_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .async_i({tgt_parity_err_i, init_wr_perr_seen_i, init_rd_parity_err_i,
                  tgt_target_abort_i, init_target_abort_i, satellite_mode_i, pci_clk_i}),
        .sync_o(sy)
    );

    // link clock edge finder
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pclk_prev_q <= 1'b0;
        end else if (ce_i) begin
            pclk_prev_q <= sy[SY_PCLK];
        end
    end

    assign pedge = sy[SY_PCLK] & ~pclk_prev_q;

    // ========================================================================
    // register write: local writes locked out in satellite mode
    assign wr_en = cfg_we_i | (cpu_we_i & ~sy[SY_SAT]);
    assign wr_data = cfg_we_i ? cfg_wdata_i : cpu_wdata_i;

    // parity error response control bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            parity_error_response_enable <= PERR_RESP_RESET;
        end else if (ce_i && wr_en) begin
            parity_error_response_enable <= wr_data[POS_PERR_RESP];
        end
    end

    // ========================================================================
    // status events taken at the link clock edge
    assign init_perr_event = pedge & (sy[SY_RD_PERR] | sy[SY_WR_PERR]);
    assign bus_perr_event = pedge & (sy[SY_RD_PERR] | sy[SY_TGT_PERR]);

    assign st.set[IDX_REMOTE_TABORT] = pedge & sy[SY_INIT_TABORT];
    assign st.set[IDX_TARGET_TABORT] = pedge & sy[SY_TGT_TABORT];
    assign st.set[IDX_INIT_PARITY] = init_perr_event & parity_error_response_enable;
    assign st.set[IDX_BUS_PARITY] = bus_perr_event;

    // clear only where a one is written
    assign st.clr[IDX_REMOTE_TABORT] = wr_en & wr_data[POS_REMOTE_TABORT];
    assign st.clr[IDX_TARGET_TABORT] = wr_en & wr_data[POS_TARGET_TABORT];
    assign st.clr[IDX_INIT_PARITY] = wr_en & wr_data[POS_INIT_PARITY_ERR];
    assign st.clr[IDX_BUS_PARITY] = wr_en & wr_data[POS_BUS_PARITY_ERR];

    pscb_w1c_bank u_bank (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .st(st)
    );

    // ========================================================================
    // parity error pin: driven only when the response is enabled
    assign perr_drive = bus_perr_event & parity_error_response_enable;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            perr_oe_o <= 1'b0;
            perr_n_o <= 1'b1;
        end else if (ce_i) begin
            perr_oe_o <= perr_drive;
            perr_n_o <= ~perr_drive;
        end
    end

    // ========================================================================
    // read value assembly
    always_comb begin
        rd_value = '0;
        rd_value[POS_BUS_PARITY_ERR] = st.q[IDX_BUS_PARITY];
        rd_value[POS_REMOTE_TABORT] = st.q[IDX_REMOTE_TABORT];
        rd_value[POS_TARGET_TABORT] = st.q[IDX_TARGET_TABORT];
        rd_value[POS_DEVSEL_HI:POS_DEVSEL_LO] = DEVSEL_MEDIUM;
        rd_value[POS_INIT_PARITY_ERR] = st.q[IDX_INIT_PARITY];
        rd_value[POS_FAST_B2B] = FAST_B2B_VAL;
        rd_value[POS_USER_FEATURES] = USER_FEATURES_VAL;
        rd_value[POS_CAP_66MHZ] = CAP_66MHZ_VAL;
        rd_value[POS_CAP_LIST] = CAP_LIST_VAL;
        rd_value[POS_INT_STATUS] = INT_STATUS_VAL;
        rd_value[POS_INT_DISABLE] = INT_DISABLE_VAL;
        rd_value[POS_PERR_RESP] = parity_error_response_enable;
    end

    // registered read data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= RDATA_RESET;
        end else if (ce_i) begin
            rdata_o <= rd_value;
        end
    end

    // ========================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_remote_abort;
        ce_i && pedge && sy[SY_INIT_TABORT];
    endsequence

    sequence s_target_abort;
        ce_i && pedge && sy[SY_TGT_TABORT];
    endsequence

    sequence s_init_perr_enabled;
        ce_i && init_perr_event && parity_error_response_enable;
    endsequence

    a_remote_abort_set: assert property (s_remote_abort |=> st.q[IDX_REMOTE_TABORT])
        else $error("remote target abort not recorded");

    a_target_abort_set: assert property (s_target_abort |=> st.q[IDX_TARGET_TABORT])
        else $error("target abort not recorded");

    a_zero_write_keeps: assert property (ce_i && wr_en && !wr_data[POS_REMOTE_TABORT]
        && !wr_data[POS_TARGET_TABORT] && st.q[IDX_REMOTE_TABORT] && st.q[IDX_TARGET_TABORT]
        |=> st.q[IDX_REMOTE_TABORT] && st.q[IDX_TARGET_TABORT])
        else $error("zero write changed a status bit");

    a_devsel_medium: assert property (ce_i |=> rdata_o[POS_DEVSEL_HI:POS_DEVSEL_LO] == 2'h1)
        else $error("device select timing not medium");

    a_init_perr_set: assert property (s_init_perr_enabled |=> ##1 rdata_o[POS_INIT_PARITY_ERR])
        else $error("initiator parity error not shown");

    a_init_perr_gate: assert property (ce_i && !parity_error_response_enable && !st.q[IDX_INIT_PARITY]
        |=> !st.q[IDX_INIT_PARITY])
        else $error("initiator parity error set while response disabled");

    a_fixed_bits: assert property (ce_i |=> rdata_o[POS_FAST_B2B] && !rdata_o[POS_USER_FEATURES]
        && !rdata_o[POS_CAP_LIST] && !rdata_o[POS_INT_STATUS] && !rdata_o[POS_INT_DISABLE])
        else $error("fixed capability bits wrong");

    a_perr_pin_gate: assert property (perr_oe_o |-> $past(parity_error_response_enable)
        && !perr_n_o)
        else $error("parity error pin driven while response disabled");

    a_satellite_lock: assert property (ce_i && cpu_we_i && !cfg_we_i && sy[SY_SAT]
        |=> $stable(parity_error_response_enable))
        else $error("local write took effect in satellite mode");

    a_set_beats_clear: assert property (ce_i && st.set[IDX_REMOTE_TABORT] && st.clr[IDX_REMOTE_TABORT]
        |=> st.q[IDX_REMOTE_TABORT] ##1 (!ce_i || rdata_o[POS_REMOTE_TABORT]))
        else $error("clearing write lost a new event");

endmodule : pscb_status_command

`default_nettype wire

/* File: pscb_pkg.sv */
// package: field positions, fixed values and reset values of the status/command register
package pscb_pkg;

    // ========================================================================
    // register shape
    localparam int unsigned REG_W = 32;
    localparam int unsigned STAT_N = 4;

    // ========================================================================
    // field positions
    localparam int unsigned POS_BUS_PARITY_ERR = 31;
    localparam int unsigned POS_REMOTE_TABORT = 28;
    localparam int unsigned POS_TARGET_TABORT = 27;
    localparam int unsigned POS_DEVSEL_HI = 26;
    localparam int unsigned POS_DEVSEL_LO = 25;
    localparam int unsigned POS_INIT_PARITY_ERR = 24;
    localparam int unsigned POS_FAST_B2B = 23;
    localparam int unsigned POS_USER_FEATURES = 22;
    localparam int unsigned POS_CAP_66MHZ = 21;
    localparam int unsigned POS_CAP_LIST = 20;
    localparam int unsigned POS_INT_STATUS = 19;
    localparam int unsigned POS_INT_DISABLE = 10;
    localparam int unsigned POS_PERR_RESP = 6;

    // ========================================================================
    // index of each sticky status bit inside the status bank
    localparam int unsigned IDX_INIT_PARITY = 0;
    localparam int unsigned IDX_TARGET_TABORT = 1;
    localparam int unsigned IDX_REMOTE_TABORT = 2;
    localparam int unsigned IDX_BUS_PARITY = 3;

    // ========================================================================
    // fixed read values
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic FAST_B2B_VAL = 1'h1;
    localparam logic USER_FEATURES_VAL = 1'h0;
    localparam logic CAP_66MHZ_VAL = 1'h0;
    localparam logic CAP_LIST_VAL = 1'h0;
    localparam logic INT_STATUS_VAL = 1'h0;
    localparam logic INT_DISABLE_VAL = 1'h0;

    // ========================================================================
    // reset values
    localparam logic [STAT_N-1:0] STAT_RESET = 4'h0;
    localparam logic PERR_RESP_RESET = 1'h0;
    localparam logic [REG_W-1:0] RDATA_RESET = 32'h02800000;

    // ========================================================================
    // link input bundle: positions inside the synchroniser vector
    localparam int unsigned SYNC_W = 7;
    localparam int unsigned SY_PCLK = 0;
    localparam int unsigned SY_SAT = 1;
    localparam int unsigned SY_INIT_TABORT = 2;
    localparam int unsigned SY_TGT_TABORT = 3;
    localparam int unsigned SY_RD_PERR = 4;
    localparam int unsigned SY_WR_PERR = 5;
    localparam int unsigned SY_TGT_PERR = 6;

endpackage : pscb_pkg

/* File: pscb_stat_if.sv */
// interface: set, clear and state of the sticky status bits
`timescale 1ns/1ps
`default_nettype none

interface pscb_stat_if;
    import pscb_pkg::*;
    logic [STAT_N-1:0] set;
    logic [STAT_N-1:0] clr;
    logic [STAT_N-1:0] q;

    modport ctl (output set, output clr, input q);
    modport bank (input set, input clr, output q);
endinterface : pscb_stat_if

`default_nettype wire

/* File: pscb_sync.sv */
// module: two-flop synchroniser for the link-side inputs
`timescale 1ns/1ps
`default_nettype none

module pscb_sync import pscb_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // asynchronous inputs and their synchronised copies
    input wire logic [SYNC_W-1:0] async_i,
    output logic [SYNC_W-1:0] sync_o
);
    logic [SYNC_W-1:0] meta_q;

    // ========================================================================
    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : pscb_sync

`default_nettype wire

/* File: pscb_w1c_bank.sv */
// module: sticky status bits, set by hardware, cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module pscb_w1c_bank import pscb_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // set, clear and state
    pscb_stat_if.bank st
);
    genvar i;

    // ========================================================================
    // one sticky flop per bit; a set in the clearing cycle wins
    generate
        for (i = 0; i < STAT_N; i++) begin : g_bit
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    st.q[i] <= STAT_RESET[i];
                end else if (ce_i) begin
                    if (st.set[i]) begin
                        st.q[i] <= 1'b1;
                    end else if (st.clr[i]) begin
                        st.q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule : pscb_w1c_bank

`default_nettype wire

/* File: pscb_link_model.sv */
// module: behavioural model of the far-side link agent that drives the link clock and event lines
`timescale 1ns/1ps
`default_nettype none

module pscb_link_model (
    // clock
    input wire logic clk_i,
    // link clock and event lines
    output logic pci_clk_o,
    output logic [4:0] ev_o
);
    // ========================================================================
    // idle state: link clock stands still low, no event asserted
    initial begin
        pci_clk_o = 1'h0;
        ev_o = 5'h00;
    end

    // ========================================================================
    // one link clock period of 13 clocks (650 ns), events held well across the rising edge
    task automatic frame(input logic [4:0] ev);
        @(posedge clk_i);
        ev_o <= ev; // events valid before the edge
        repeat (4) @(posedge clk_i);
        pci_clk_o <= 1'h1;
        repeat (4) @(posedge clk_i);
        pci_clk_o <= 1'h0;
        ev_o <= 5'h00; // released only after the hold time
        repeat (4) @(posedge clk_i);
    endtask : frame
endmodule : pscb_link_model

`default_nettype wire

/* File: tb_top.sv */
// testbench: register writes and link events against the status/command register
`timescale 1ns/1ps
`default_nettype none

module tb_top import pscb_pkg::*;;
    logic clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic ce_i = 1'h1;
    logic sat = 1'h0;
    logic cpu_we = 1'h0;
    logic cfg_we = 1'h0;
    logic [REG_W-1:0] cpu_wd = 32'h00000000;
    logic [REG_W-1:0] cfg_wd = 32'h00000000;
    logic [REG_W-1:0] rdata;
    logic perr_n;
    logic perr_oe;
    logic pclk;
    logic [4:0] ev;
    logic [REG_W-1:0] exp_q;
    int failures = 0;
    int comparisons = 0;
    int perr_drives = 0;

    // ========================================================================
    // design and far-side model
    pscb_status_command u_pscb_status_command (.clk_i(clk_i), .ce_i(ce_i), .reset_n_i(reset_n_i),
        .pci_clk_i(pclk), .satellite_mode_i(sat), .init_target_abort_i(ev[0]), .tgt_target_abort_i(ev[1]),
        .init_rd_parity_err_i(ev[2]), .init_wr_perr_seen_i(ev[3]), .tgt_parity_err_i(ev[4]),
        .cpu_we_i(cpu_we), .cpu_wdata_i(cpu_wd), .cfg_we_i(cfg_we), .cfg_wdata_i(cfg_wd),
        .rdata_o(rdata), .perr_n_o(perr_n), .perr_oe_o(perr_oe));
    pscb_link_model u_pscb_link_model (.clk_i(clk_i), .pci_clk_o(pclk), .ev_o(ev));

    // ========================================================================
    // clock, parity pin monitor and watchdog
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (perr_oe === 1'h1) begin
            perr_drives++;
            if (perr_n !== 1'h0) begin
                failures++;
                $display("CHECK FAILED t=%0t parity pin driven high", $time);
            end
        end
    end

    initial begin
        #2000000;
        failures++;
        complete_run();
    end

    // ========================================================================
    // verdict and compare tasks
    task automatic complete_run();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk_reg();
        comparisons++;
        if (rdata !== exp_q) begin
            failures++;
            $display("CHECK FAILED t=%0t rdata %h expected %h", $time, rdata, exp_q);
        end
    endtask : chk_reg

    task automatic chk_drives(input int exp);
        comparisons++;
        if (perr_drives != exp) begin
            failures++;
            $display("CHECK FAILED t=%0t parity drives %0d expected %0d", $time, perr_drives, exp);
        end
    endtask : chk_drives

    // ========================================================================
    // access tasks: one-cycle write strobe, link frame, then settle
    task automatic wr(input logic cfg, input logic [REG_W-1:0] d);
        @(posedge clk_i);
        if (cfg) begin
            cfg_we <= 1'h1;
            cfg_wd <= d;
        end else begin
            cpu_we <= 1'h1;
            cpu_wd <= d;
        end
        @(posedge clk_i);
        cfg_we <= 1'h0;
        cpu_we <= 1'h0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : wr

    task automatic link(input logic [4:0] e);
        u_pscb_link_model.frame(e);
        repeat (3) @(posedge clk_i);
        #1;
    endtask : link

    // ========================================================================
    // main sequence
    initial begin
        exp_q = RDATA_RESET;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        #1;
        chk_reg();
        link(5'h01);
        exp_q[POS_REMOTE_TABORT] = 1'h1;
        chk_reg();
        link(5'h02);
        exp_q[POS_TARGET_TABORT] = 1'h1;
        chk_reg();
        wr(1'h0, 32'h00000000);
        chk_reg();
        wr(1'h0, 32'h10000000);
        exp_q[POS_REMOTE_TABORT] = 1'h0;
        chk_reg();
        wr(1'h1, 32'h00780400);
        chk_reg();
        link(5'h04);
        exp_q[POS_BUS_PARITY_ERR] = 1'h1;
        chk_reg();
        chk_drives(0);
        wr(1'h0, 32'h88000040);
        exp_q[POS_BUS_PARITY_ERR] = 1'h0;
        exp_q[POS_TARGET_TABORT] = 1'h0;
        exp_q[POS_PERR_RESP] = 1'h1;
        chk_reg();
        link(5'h04);
        exp_q[POS_BUS_PARITY_ERR] = 1'h1;
        exp_q[POS_INIT_PARITY_ERR] = 1'h1;
        chk_reg();
        chk_drives(1);
        wr(1'h0, 32'h81000040);
        exp_q[POS_BUS_PARITY_ERR] = 1'h0;
        exp_q[POS_INIT_PARITY_ERR] = 1'h0;
        chk_reg();
        link(5'h08);
        exp_q[POS_INIT_PARITY_ERR] = 1'h1;
        chk_reg();
        link(5'h10);
        exp_q[POS_BUS_PARITY_ERR] = 1'h1;
        chk_reg();
        chk_drives(2);
        link(5'h00);
        chk_reg();
        // clearing write lands in the very cycle of a new abort event: the event wins
        fork
            link(5'h01);
            begin
                repeat (7) @(posedge clk_i);
                cpu_we <= 1'h1;
                cpu_wd <= 32'h10000040;
                @(posedge clk_i);
                cpu_we <= 1'h0;
            end
        join
        exp_q[POS_REMOTE_TABORT] = 1'h1;
        chk_reg();
        @(posedge clk_i);
        sat <= 1'h1;
        repeat (4) @(posedge clk_i);
        wr(1'h0, 32'h99000000);
        chk_reg();
        wr(1'h1, 32'h99000000);
        exp_q = RDATA_RESET;
        chk_reg();
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
